// >>> verilog/tvg_schedule.sv
// Time-varying gain schedule registers and sequencer
`timescale 1ns/1ps
`default_nettype none
`include "tvg_consts.svh"
module tvg_schedule import tvg_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `TVG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Earlier schedule settings held elsewhere
  input wire logic [3:0] i_schedule_start_code,
  input wire logic [3:0] i_segment1_delta_code,
  input wire logic [3:0] i_segment2_delta_code,
  input wire logic [3:0] i_segment3_delta_code,
  input wire tvg_code_t i_initial_gain_code,
  input wire logic [7:0] i_front_end_gain_range,
  input wire logic [7:0] i_base_freq_code,
  // Listening control
  input wire logic i_listen_start,
  input wire logic i_listen_stop,
  // Front-end outputs
  output logic [9:0] o_gain_half_db,
  output logic [2:0] o_gain_point,
  output logic o_listening,
  output logic [12:0] o_burst_freq_dkhz
);

  // Register storage
  logic [7:0] gain_schedule_reg2;
  logic [7:0] gain_schedule_reg3;
  logic [7:0] gain_schedule_reg4;
  logic [7:0] gain_schedule_reg5;
  logic [7:0] gain_schedule_reg6;

  // Address decode
  wire sel_reg2 = (i_addr == `TVG_ADDR_REG2);
  wire sel_reg3 = (i_addr == `TVG_ADDR_REG3);
  wire sel_reg4 = (i_addr == `TVG_ADDR_REG4);
  wire sel_reg5 = (i_addr == `TVG_ADDR_REG5);
  wire sel_reg6 = (i_addr == `TVG_ADDR_REG6);

  wire [7:0] read_mux =
    sel_reg2 ? gain_schedule_reg2 :
    sel_reg3 ? gain_schedule_reg3 :
    sel_reg4 ? gain_schedule_reg4 :
    sel_reg5 ? gain_schedule_reg5 :
    sel_reg6 ? gain_schedule_reg6 :
    `TVG_RDATA_UNMAPPED;

  // Write enables, one per register
  wire wr_reg2 = i_wr && sel_reg2;
  wire wr_reg3 = i_wr && sel_reg3;
  wire wr_reg4 = i_wr && sel_reg4;
  wire wr_reg5 = i_wr && sel_reg5;
  wire wr_reg6 = i_wr && sel_reg6;

  // Whole bytes are writable, the reserved bit included
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_schedule_reg2 <= `TVG_REG_RESET;
    end else if (wr_reg2) begin
      gain_schedule_reg2 <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_schedule_reg3 <= `TVG_REG_RESET;
    end else if (wr_reg3) begin
      gain_schedule_reg3 <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_schedule_reg4 <= `TVG_REG_RESET;
    end else if (wr_reg4) begin
      gain_schedule_reg4 <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_schedule_reg5 <= `TVG_REG_RESET;
    end else if (wr_reg5) begin
      gain_schedule_reg5 <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      gain_schedule_reg6 <= `TVG_REG_RESET;
    end else if (wr_reg6) begin
      gain_schedule_reg6 <= i_wdata;
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? read_mux : 8'h00;
    end
  end

  // Field extraction
  wire [3:0] segment4_delta_code = gain_schedule_reg2[`TVG_SEG4_HI:`TVG_SEG4_LO];
  wire [3:0] segment5_delta_code = gain_schedule_reg2[`TVG_SEG5_HI:`TVG_SEG5_LO];
  wire burst_range_multiplier_en = gain_schedule_reg6[`TVG_SHIFT_BIT];

  tvg_points_t points;
  assign points.p1 = gain_schedule_reg3[`POINT1_GAIN_CODE_HI:`POINT1_GAIN_CODE_LO];
  assign points.p2 = {gain_schedule_reg3[`TVG_G2A_HI:`TVG_G2A_LO],
                      gain_schedule_reg4[`TVG_G2B_HI:`TVG_G2B_LO]};
  assign points.p3 = {gain_schedule_reg4[`TVG_G3A_HI:`TVG_G3A_LO],
                      gain_schedule_reg5[`TVG_G3B_HI:`TVG_G3B_LO]};
  assign points.p4 = gain_schedule_reg5[`POINT4_GAIN_CODE_HI:`POINT4_GAIN_CODE_LO];
  assign points.p5 = gain_schedule_reg6[`POINT5_GAIN_CODE_HI:`POINT5_GAIN_CODE_LO];

  // Microsecond tick, realigned at each start
  logic tick;
  tvg_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_clear(i_listen_start),
    .o_tick(tick)
  );

  // Sequencer state
  tvg_state_t state;
  tvg_state_t next_state;
  logic [2:0] point;
  logic [2:0] next_point;
  logic [15:0] elapsed;
  logic [15:0] next_elapsed;
  logic [15:0] target;
  logic [15:0] next_target;

  // Delta of the segment after the one just ending, added on leaving a point
  wire [3:0] next_seg_code =
    (point == 3'h0) ? i_segment2_delta_code :
    (point == 3'h1) ? i_segment3_delta_code :
    (point == 3'h2) ? segment4_delta_code :
    segment5_delta_code;

  // First point lies at start time plus the first delta
  wire [15:0] first_target = tvg_delay_us(i_schedule_start_code)
                           + tvg_delay_us(i_segment1_delta_code);
  wire [15:0] seg_delta = tvg_delay_us(next_seg_code);
  wire reached = tick && (elapsed + 16'h0001 >= target);

  always_comb begin
    next_state = state;
    next_point = point;
    next_elapsed = elapsed;
    next_target = target;
    unique case (state)
      TVG_IDLE: begin
        if (i_listen_start) begin
          next_state = TVG_RUN;
          next_point = 3'h0;
          next_elapsed = 16'h0000;
          next_target = first_target;
        end
      end
      TVG_RUN: begin
        if (tick) begin
          next_elapsed = elapsed + 16'h0001;
        end
        if (reached) begin
          next_point = point + 3'h1;
          next_target = target + seg_delta;
          if (point + 3'h1 == `TVG_LAST_POINT) begin
            next_state = TVG_HOLD;
          end
        end
      end
      TVG_HOLD: begin
        next_state = TVG_HOLD;
      end
      default: next_state = TVG_IDLE;
    endcase
    // Stop wins over everything; a restart reopens the schedule
    if (i_listen_stop) begin
      next_state = TVG_IDLE;
      next_point = 3'h0;
    end else if (i_listen_start && state != TVG_IDLE) begin
      next_state = TVG_RUN;
      next_point = 3'h0;
      next_elapsed = 16'h0000;
      next_target = first_target;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= TVG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      point <= 3'h0;
    end else begin
      point <= next_point;
    end
  end

  // Elapsed time only counts ticks; a restart clears it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      elapsed <= 16'h0000;
    end else begin
      elapsed <= next_elapsed;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      target <= 16'h0000;
    end else begin
      target <= next_target;
    end
  end

  // Gain code of the point in force
  wire tvg_code_t active_code =
    (point == 3'h1) ? points.p1 :
    (point == 3'h2) ? points.p2 :
    (point == 3'h3) ? points.p3 :
    (point == 3'h4) ? points.p4 :
    (point == 3'h5) ? points.p5 :
    i_initial_gain_code;

  tvg_gain_calc u_gain (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_code(active_code),
    .i_range_db(i_front_end_gain_range),
    .o_gain_half_db(o_gain_half_db)
  );

  // Burst frequency in 0.1 kHz units
  wire [12:0] base_freq = 13'(i_base_freq_code) * 13'(`TVG_FREQ_STEP)
                        + 13'(`TVG_FREQ_BASE);
  wire [12:0] next_freq = burst_range_multiplier_en
                        ? base_freq * 13'(`TVG_BURST_RANGE_MULTIPLIER_EN_MULT)
                        : base_freq;

  // Point and flag registered alongside the gain, one cycle behind the state
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_gain_point <= 3'h0;
    end else begin
      o_gain_point <= point;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_listening <= 1'b0;
    end else begin
      o_listening <= (state != TVG_IDLE);
    end
  end

  // Recomputed every cycle, so a new code or shift shows one cycle later
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_burst_freq_dkhz <= 13'h0000;
    end else begin
      o_burst_freq_dkhz <= next_freq;
    end
  end

endmodule : tvg_schedule
`default_nettype wire

// >>> verilog/tvg_consts.svh
// Constants for the time-varying gain schedule block
`ifndef TVG_CONSTS_SVH
`define TVG_CONSTS_SVH

// Register byte addresses
`define TVG_ADDR_REG2 8'h16
`define TVG_ADDR_REG3 8'h17
`define TVG_ADDR_REG4 8'h18
`define TVG_ADDR_REG5 8'h19
`define TVG_ADDR_REG6 8'h1a

// Reset value and unmapped read data
`define TVG_REG_RESET 8'h00
`define TVG_RDATA_UNMAPPED 8'h00

// Field positions in gain_schedule_reg2
`define TVG_SEG4_HI 7
`define TVG_SEG4_LO 4
`define TVG_SEG5_HI 3
`define TVG_SEG5_LO 0

// Field positions of the gain codes, the reserved bit and the shift bit
`define POINT1_GAIN_CODE_HI 7
`define POINT1_GAIN_CODE_LO 2
`define TVG_G2A_HI 1
`define TVG_G2A_LO 0
`define TVG_G2B_HI 7
`define TVG_G2B_LO 4
`define TVG_G3A_HI 3
`define TVG_G3A_LO 0
`define TVG_G3B_HI 7
`define TVG_G3B_LO 6
`define POINT4_GAIN_CODE_HI 5
`define POINT4_GAIN_CODE_LO 0
`define POINT5_GAIN_CODE_HI 7
`define POINT5_GAIN_CODE_LO 2
`define TVG_RSVD_BIT 1
`define TVG_SHIFT_BIT 0

// Timing
`define TVG_CLK_HZ 20000000
`define TVG_TICK_US 1
`define TVG_TICK_CYCLES ((`TVG_CLK_HZ / 1000000) * `TVG_TICK_US)

// Burst frequency in 0.1 kHz units: 2 * code + 300, optionally times 6
`define TVG_FREQ_STEP 2
`define TVG_FREQ_BASE 300
`define TVG_BURST_RANGE_MULTIPLIER_EN_MULT 6

// Gain in half-dB units: code + 1 + 2 * range offset in dB
`define TVG_GAIN_CODE_BIAS 1
`define TVG_RANGE_SCALE 2

// Last gain point index
`define TVG_LAST_POINT 3'h5

`endif

// >>> verilog/tvg_pkg.sv
// Types and delay table of the time-varying gain schedule block
package tvg_pkg;

  typedef logic [5:0] tvg_code_t;

  typedef struct packed {
    tvg_code_t p1;
    tvg_code_t p2;
    tvg_code_t p3;
    tvg_code_t p4;
    tvg_code_t p5;
  } tvg_points_t;

  typedef enum logic [1:0] {
    TVG_IDLE = 2'b00,
    TVG_RUN = 2'b01,
    TVG_HOLD = 2'b10
  } tvg_state_t;

  // Segment code to delay in microseconds
  function automatic logic [15:0] tvg_delay_us(input logic [3:0] code);
    logic [15:0] us;
    us = 16'h0000;
    unique case (code)
      4'h0: us = 16'd100;
      4'h1: us = 16'd200;
      4'h2: us = 16'd300;
      4'h3: us = 16'd400;
      4'h4: us = 16'd600;
      4'h5: us = 16'd800;
      4'h6: us = 16'd1000;
      4'h7: us = 16'd1200;
      4'h8: us = 16'd1400;
      4'h9: us = 16'd2000;
      4'ha: us = 16'd2400;
      4'hb: us = 16'd3200;
      4'hc: us = 16'd4000;
      4'hd: us = 16'd5200;
      4'he: us = 16'd6400;
      4'hf: us = 16'd8000;
    endcase
    return us;
  endfunction : tvg_delay_us

endpackage : tvg_pkg

// >>> verilog/tvg_tick_div.sv
// Microsecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
`include "tvg_consts.svh"
module tvg_tick_div import tvg_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `TVG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Control
  input wire logic i_clear,
  output logic o_tick
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic wrap;

  assign wrap = (count == 8'(TICK_CYCLES - 1));
  assign next_count = (i_clear || wrap) ? 8'h00 : count + 8'h01;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      count <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      count <= next_count;
      o_tick <= wrap && !i_clear;
    end
  end

endmodule : tvg_tick_div
`default_nettype wire

// >>> verilog/tvg_gain_calc.sv
// Gain code plus front-end range offset to half-dB units
`timescale 1ns/1ps
`default_nettype none
`include "tvg_consts.svh"
module tvg_gain_calc import tvg_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Operands
  input wire tvg_code_t i_code,
  input wire logic [7:0] i_range_db,
  // Result
  output logic [9:0] o_gain_half_db
);

  logic [9:0] next_gain;

  // Half-dB units keep the 0.5 dB step exact in integers
  assign next_gain = 10'(i_code) + 10'(`TVG_GAIN_CODE_BIAS)
                   + 10'(i_range_db) * 10'(`TVG_RANGE_SCALE);

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_gain_half_db <= 10'h000;
    end else begin
      o_gain_half_db <= next_gain;
    end
  end

endmodule : tvg_gain_calc
`default_nettype wire

// >>> testbench/tvg_schedule_monitor.sv
// Port assertions for the gain schedule block
`timescale 1ns/1ps
`default_nettype none
module tvg_schedule_monitor import tvg_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Schedule side
  input wire tvg_code_t i_initial_gain_code,
  input wire logic [7:0] i_front_end_gain_range,
  input wire logic [7:0] i_base_freq_code,
  input wire logic i_listen_start,
  input wire logic i_listen_stop,
  input wire logic [9:0] o_gain_half_db,
  input wire logic [2:0] o_gain_point,
  input wire logic o_listening,
  input wire logic [12:0] o_burst_freq_dkhz
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic shift_en;
  wire map_hit = i_addr >= 8'h16 && i_addr <= 8'h1a;
  // Shadow of the shift bit, hidden behind the ports
  always_ff @(posedge i_mclk) begin
    if (i_reset) shift_en <= 1'b0;
    else if (i_wr && i_addr == 8'h1a) shift_en <= i_wdata[0];
  end
  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
  chk_unmapped_read: assert property (i_rd && !map_hit |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_write_readback: assert property (
    i_wr && map_hit ##1 i_rd && !i_wr && $stable(i_addr) |=> o_rdata == $past(i_wdata, 2))
    else $error("readback differs");
  chk_freq_calc: assert property (
    !$past(i_reset) |-> o_burst_freq_dkhz ==
    13'((2 * $past(i_base_freq_code) + 300) * ($past(shift_en) ? 6 : 1)))
    else $error("burst frequency wrong");
  chk_gain_initial: assert property (
    o_gain_point == 3'h0 && !$past(i_reset) |-> o_gain_half_db ==
    10'($past(i_initial_gain_code) + 1 + 2 * $past(i_front_end_gain_range)))
    else $error("initial gain wrong");
  chk_start_listen: assert property (
    i_listen_start && !i_listen_stop |-> ##[1:2] o_listening)
    else $error("start not taken");
  chk_stop_quiet: assert property (i_listen_stop |-> ##2 !o_listening)
    else $error("stop not taken");
  chk_restart_zero: assert property (
    i_listen_start && !i_listen_stop |-> ##2 o_gain_point == 3'h0)
    else $error("start not at point zero");
endmodule : tvg_schedule_monitor
`default_nettype wire

// >>> testbench/tvg_schedule_bench.sv
// Self-checking bench for the gain schedule block
`timescale 1ns/1ps
`default_nettype none
module tvg_schedule_bench import tvg_pkg::*;;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_listen_start = 1'b0, i_listen_stop = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic [7:0] i_front_end_gain_range = 8'h00, i_base_freq_code = 8'h00;
  logic [3:0] i_schedule_start_code = 4'h0, i_segment1_delta_code = 4'h0;
  logic [3:0] i_segment2_delta_code = 4'h0, i_segment3_delta_code = 4'h0;
  tvg_code_t i_initial_gain_code = 6'h00;
  logic [7:0] o_rdata;
  logic [9:0] o_gain_half_db;
  logic [2:0] o_gain_point;
  logic o_listening;
  logic [12:0] o_burst_freq_dkhz;
  int n_errors = 0, check_count = 0, cyc = 0, mdl[5];
  int dly[16] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400, 2000, 2400, 3200, 4000,
    5200, 6400, 8000};
  logic [31:0] seed = 32'h305;
  // One cycle per microsecond keeps the long segments affordable
  tvg_schedule #(.TICK_CYCLES(1)) tvg_schedule_inst (.i_mclk, .i_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_schedule_start_code, .i_segment1_delta_code,
    .i_segment2_delta_code, .i_segment3_delta_code, .i_initial_gain_code,
    .i_front_end_gain_range, .i_base_freq_code, .i_listen_start, .i_listen_stop,
    .o_gain_half_db, .o_gain_point, .o_listening, .o_burst_freq_dkhz);
  always #25 i_mclk = ~i_mclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Both tasks start and end on a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a >= 8'h16 && a <= 8'h1a) mdl[a - 8'h16] = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 check(16'(o_rdata), 16'(exp));
    @(posedge i_mclk);
  endtask : rd
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int a = 8'h15; a <= 8'h1b; a++) rd(8'(a), 8'h00);
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'h00);
    wr(8'h1a, 8'h02);
    rd(8'h1a, 8'h02);
    for (int i = 0; i < 10; i++) begin
      logic [7:0] d;
      d = 8'(rnd());
      wr(8'(8'h16 + i % 5), d);
      rd(8'(8'h16 + i % 5), d);
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h1a, {mdl[4][7:1], s[0]});
      i_base_freq_code <= 8'(rnd() % 251);
      repeat (2) @(posedge i_mclk);
      #1 check(16'(o_burst_freq_dkhz), 16'((2 * i_base_freq_code + 300) * (s ? 6 : 1)));
      @(posedge i_mclk);
    end
    for (int r = 0; r < 2; r++) begin
      logic [3:0] t[6];
      logic [5:0] g[6];
      int tot, n;
      // Short early segments bound the run length
      for (int k = 0; k < 4; k++) t[k] = 4'(rnd() & 32'h7);
      // An idle edge between writes keeps each strobe a clean pulse
      for (int a = 0; a < 5; a++) begin
        wr(8'(8'h16 + a), 8'(rnd()));
        @(posedge i_mclk);
      end
      t[4] = mdl[0][7:4];
      t[5] = mdl[0][3:0];
      g[0] = 6'(rnd());
      g[1] = mdl[1][7:2];
      g[2] = {mdl[1][1:0], mdl[2][7:4]};
      g[3] = {mdl[2][3:0], mdl[3][7:6]};
      g[4] = mdl[3][5:0];
      g[5] = mdl[4][7:2];
      i_schedule_start_code <= t[0];
      i_segment1_delta_code <= t[1];
      i_segment2_delta_code <= t[2];
      i_segment3_delta_code <= t[3];
      i_initial_gain_code <= g[0];
      i_front_end_gain_range <= 8'(rnd() % 40);
      @(posedge i_mclk);
      i_listen_start <= 1'b1;
      @(posedge i_mclk);
      i_listen_start <= 1'b0;
      repeat (3) @(posedge i_mclk);
      #1 check(16'(o_gain_half_db), 16'(g[0] + 1 + 2 * i_front_end_gain_range));
      n = 3;
      tot = dly[t[0]];
      for (int k = 1; k <= 5; k++) begin
        tot += dly[t[k]];
        while (o_gain_point !== 3'(k) && n < tot + 10) begin
          @(posedge i_mclk);
          #1 n++;
        end
        check(16'(n >= tot && n <= tot + 4), 16'h1);
        check(16'(o_gain_half_db), 16'(g[k] + 1 + 2 * i_front_end_gain_range));
      end
      if (r == 0) begin
        // Start while holding reopens the schedule at point zero
        @(posedge i_mclk);
        i_listen_start <= 1'b1;
        @(posedge i_mclk);
        i_listen_start <= 1'b0;
        repeat (2) @(posedge i_mclk);
        #1 check(16'({o_listening, o_gain_point}), 16'h8);
        check(16'(o_gain_half_db), 16'(g[0] + 1 + 2 * i_front_end_gain_range));
      end
      @(posedge i_mclk);
      i_listen_stop <= 1'b1;
      @(posedge i_mclk);
      i_listen_stop <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 check(16'(o_listening), 16'h0);
      @(posedge i_mclk);
    end
    final_report();
  end
endmodule : tvg_schedule_bench
bind tvg_schedule tvg_schedule_monitor tvg_schedule_monitor_inst (.i_mclk, .i_reset, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_initial_gain_code, .i_front_end_gain_range,
  .i_base_freq_code, .i_listen_start, .i_listen_stop, .o_gain_half_db, .o_gain_point,
  .o_listening, .o_burst_freq_dkhz);
`default_nettype wire
